//--- spcr_host_model.sv
/*
  spcr_host_model: host controller that drives the serial control port.
  Assumes the device answers on sdio or the separate output pin after the instruction.
*/
`timescale 1ns/1ps
`default_nettype none

module spcr_host_model import spcr_pkg::*; (
  // serial link to the device
  output logic      sclk,
  output logic      cs_n,
  output wire logic sdio_in,
  // device answer lines
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe
);
  logic host_oe;
  logic host_d;
  logic float_q;
  logic saw_sdio_oe;
  logic saw_so_oe;

  // undriven line wanders instead of holding its last level
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b0;
    host_oe = 1'b0;
    host_d  = 1'b0;
    float_q = 1'b0;
    // one definite rising edge of cs_n clears the link's frame state
    #1 cs_n = 1'b1;
    forever #7 float_q = ~float_q;
  end

  // two-way pin level from every party's enable
  assign sdio_in = host_oe ? host_d : (sdio_oe ? sdio_out : float_q);

  // one bit out, captured by the device on the rising edge
  task automatic send(input logic b);
    host_d = b;
    #15 sclk = 1'b1;
    #15 sclk = 1'b0;
  endtask

  // one whole frame: instruction, then n bytes in the chosen bit order
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic lsb,
                      input int n, input logic [31:0] wdata, output logic [31:0] rdata);
    logic [15:0] ins;
    int          idx;
    ins         = {rd, 2'b00, addr};
    rdata       = '0;
    saw_sdio_oe = 1'b0;
    saw_so_oe   = 1'b0;
    #2.3 cs_n   = 1'b0;
    host_oe     = 1'b1;
    for (int i = 0; i < 16; i++) send(ins[lsb ? i : 15 - i]);
    host_oe = !rd;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        idx = 8 * k + (lsb ? i : 7 - i);
        if (rd) begin
          #15 sclk = 1'b1;
          rdata[idx] = sdio_oe ? sdio_out : (serial_out_oe ? serial_out_pin : float_q);
          saw_sdio_oe |= sdio_oe;
          saw_so_oe   |= serial_out_oe;
          #15 sclk = 1'b0;
        end else begin
          send(wdata[idx]);
        end
      end
    end
    #15 cs_n = 1'b1;
    host_oe  = 1'b0;
    #40;
  endtask
endmodule

`default_nettype wire

//--- spcr_if.sv
/*
  spcr_if: carrier between the link-side shifter and the register core.
  Assumes write fields stay stable from one toggle of wr_tgl to the next.
*/
`timescale 1ns/1ps
`default_nettype none

interface spcr_if;
  import spcr_pkg::*;

  // write path, link to core
  logic              wr_tgl;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  // read path and port modes
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              pin_sel;
  logic              lsb_first;

  modport link (output wr_tgl, wr_addr, wr_data, rd_addr,
                input  rd_data, pin_sel, lsb_first);
  modport core (input  wr_tgl, wr_addr, wr_data, rd_addr,
                output rd_data, pin_sel, lsb_first);
endinterface

`default_nettype wire

//--- spcr_link.sv
/*
  spcr_link: serial-clock side of the port; shifts instruction and data.
  Assumes cs_n is high between frames and sclk idles outside frames.
*/
`timescale 1ns/1ps
`default_nettype none

module spcr_link import spcr_pkg::*; (
  // serial link
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic rstn,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  output logic      serial_out_pin,
  output logic      serial_out_oe,
  // core side
  spcr_if.link      ifc
);

  logic [INSTR_W-1:0] sh, next_sh;
  logic [4:0]         cnt, next_cnt;
  logic               done, next_done;
  logic               rw, next_rw;
  logic [ADDR_W-1:0]  addr, next_addr;
  logic [2:0]         dbit, next_dbit;
  logic               tgl, next_tgl;
  logic [ADDR_W-1:0]  waddr, next_waddr;
  logic [7:0]         wdata, next_wdata;
  logic [7:0]         byte_nx;
  logic               out_q, rd_q;

  // byte assembly in the selected bit order
  assign byte_nx = ifc.lsb_first ? {sdio_in, sh[7:1]} : {sh[6:0], sdio_in};

  // next state of instruction, data and write posting
  always_comb begin
    next_sh    = sh;
    next_cnt   = cnt;
    next_done  = done;
    next_rw    = rw;
    next_addr  = addr;
    next_dbit  = dbit;
    next_tgl   = tgl;
    next_waddr = waddr;
    next_wdata = wdata;
    if (!done) begin
      next_sh  = ifc.lsb_first ? {sdio_in, sh[15:1]} : {sh[14:0], sdio_in};
      next_cnt = cnt + 5'h01;
      if (cnt == INSTR_LAST) begin
        next_done = 1'b1;
        next_rw   = next_sh[RW_BIT];
        next_addr = next_sh[ADDR_W-1:0];
      end
    end else begin
      next_sh   = {8'h00, byte_nx};
      next_dbit = dbit + 3'h1;
      if (dbit == BYTE_LAST) begin
        next_addr = ifc.lsb_first ? addr + 13'h0001 : addr - 13'h0001;
        if (!rw) begin
          next_tgl   = ~tgl;
          next_waddr = addr;
          next_wdata = byte_nx;
        end
      end
    end
  end

  // frame state ends with the frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sh   <= '0;
      cnt  <= '0;
      done <= 1'b0;
      rw   <= 1'b0;
      addr <= '0;
      dbit <= '0;
    end else begin
      sh   <= next_sh;
      cnt  <= next_cnt;
      done <= next_done;
      rw   <= next_rw;
      addr <= next_addr;
      dbit <= next_dbit;
    end
  end

  // posted write survives the frame end
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      tgl   <= 1'b0;
      waddr <= '0;
      wdata <= '0;
    end else begin
      tgl   <= next_tgl;
      waddr <= next_waddr;
      wdata <= next_wdata;
    end
  end

  // read bits launch on the falling edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_q <= 1'b0;
      rd_q  <= 1'b0;
    end else begin
      out_q <= ifc.rd_data[ifc.lsb_first ? dbit : BYTE_LAST - dbit];
      rd_q  <= done & rw;
    end
  end

  assign ifc.wr_tgl     = tgl;
  assign ifc.wr_addr    = waddr;
  assign ifc.wr_data    = wdata;
  assign ifc.rd_addr    = addr;
  // pin steering by output pin select
  assign sdio_out       = out_q;
  assign sdio_oe        = rd_q & ~ifc.pin_sel;
  assign serial_out_pin = out_q;
  assign serial_out_oe  = rd_q & ifc.pin_sel;

endmodule

`default_nettype wire

//--- spcr_pkg.sv
/*
  spcr_pkg: shared constants for the serial port configuration registers.
  Assumes a 13-bit register address space reached over a serial link.
*/
`default_nettype none

package spcr_pkg;

  // address and instruction layout
  localparam int ADDR_W  = 13;
  localparam int INSTR_W = 16;
  localparam int RW_BIT  = 15;
  localparam int BUF_N   = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] CFG_ADDR   = 13'h0000;
  localparam logic [ADDR_W-1:0] RBSEL_ADDR = 13'h0004;
  localparam logic [ADDR_W-1:0] BUF_BASE   = 13'h0010;

  // field positions
  localparam int CFG_PIN_SEL_BIT = 7;
  localparam int CFG_LSB_BIT     = 6;
  localparam int CFG_SRST_BIT    = 5;
  localparam int RB_PENDING_BIT  = 0;

  // reset values
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic       RBSEL_RST = 1'b0;
  localparam logic [7:0] BUF_RST   = 8'h00;

  // link bit counts
  localparam logic [4:0] INSTR_LAST = 5'h0f;
  localparam logic [2:0] BYTE_LAST  = 3'h7;

endpackage

`default_nettype wire

//--- spcr_sync.sv
/*
  spcr_sync: two-flop synchroniser bank into the core clock.
  Assumes each bit is an independent level or toggle.
*/
`timescale 1ns/1ps
`default_nettype none

module spcr_sync import spcr_pkg::*; #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // levels in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

//--- spcr_top.sv
/*
  spcr_top: serial port configuration and readback select registers,
  with a small bank of buffered settings and the serial link shifter.
  Assumes the host drives sclk/cs_n/sdio and leaves sclk idle for a few
  core clocks after each frame so writes settle before the next frame.
*/
`timescale 1ns/1ps
`default_nettype none

module spcr_top import spcr_pkg::*; (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // serial link
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               sdio_in,
  output logic                    sdio_out,
  output logic                    sdio_oe,
  output logic                    serial_out_pin,
  output logic                    serial_out_oe,
  // mode and update pins
  input  wire logic               i2c_mode,
  input  wire logic               io_update,
  // active buffered settings
  output logic [BUF_N*8-1:0]      active_regs
);

  spcr_if u_if ();

  logic [2:0]              sync_q;
  logic                    tgl_s, i2c_s, upd_s;
  logic                    wr_seen, next_wr_seen;
  logic                    upd_seen, next_upd_seen;
  logic                    wr_pulse, upd_pulse;
  logic [7:0]              cfg, next_cfg;
  logic                    rb_sel, next_rb_sel;
  logic                    srst, next_srst;
  logic [BUF_N-1:0][7:0]   pend, next_pend;
  logic [BUF_N-1:0][7:0]   act, next_act;
  logic                    buf_rd_hit;
  logic [1:0]              buf_rd_idx;

  // link-side shifter on the serial clock
  spcr_link u_link (
    .sclk           (sclk),
    .cs_n           (cs_n),
    .rstn           (rstn),
    .sdio_in        (sdio_in),
    .sdio_out       (sdio_out),
    .sdio_oe        (sdio_oe),
    .serial_out_pin (serial_out_pin),
    .serial_out_oe  (serial_out_oe),
    .ifc            (u_if)
  );

  // write toggle, mode pin and update pin into the core clock
  spcr_sync #(.WIDTH(3)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({u_if.wr_tgl, i2c_mode, io_update}),
    .q    (sync_q)
  );

  assign tgl_s     = sync_q[2];
  assign i2c_s     = sync_q[1];
  assign upd_s     = sync_q[0];
  assign wr_pulse  = tgl_s ^ wr_seen;
  assign upd_pulse = upd_s & ~upd_seen;

  // effective port modes; bit 4 and mirror bits steer nothing
  assign u_if.pin_sel   = cfg[CFG_PIN_SEL_BIT] & ~i2c_s;
  assign u_if.lsb_first = cfg[CFG_LSB_BIT] & ~i2c_s;

  // buffered register address decode for reads
  always_comb begin
    buf_rd_hit = 1'b0;
    buf_rd_idx = 2'h0;
    for (int i = 0; i < BUF_N; i++) begin
      if (u_if.rd_addr == BUF_BASE + ADDR_W'(i)) begin
        buf_rd_hit = 1'b1;
        buf_rd_idx = 2'(i);
      end
    end
  end

  // readback mux; unmapped addresses read zero
  always_comb begin
    if (u_if.rd_addr == CFG_ADDR) begin
      u_if.rd_data = cfg;
    end else if (u_if.rd_addr == RBSEL_ADDR) begin
      u_if.rd_data = {7'h00, rb_sel};
    end else if (buf_rd_hit && rb_sel) begin
      u_if.rd_data = pend[buf_rd_idx];
    end else if (buf_rd_hit) begin
      u_if.rd_data = act[buf_rd_idx];
    end else begin
      u_if.rd_data = 8'h00;
    end
  end

  // next register values: soft reset, writes, I/O update
  always_comb begin
    next_wr_seen  = tgl_s;
    next_upd_seen = upd_s;
    next_cfg      = cfg;
    next_rb_sel   = rb_sel;
    next_srst     = 1'b0;
    next_pend     = pend;
    next_act      = act;
    if (srst) begin
      next_cfg    = CFG_RST;
      next_rb_sel = RBSEL_RST;
      next_pend   = {BUF_N{BUF_RST}};
      next_act    = {BUF_N{BUF_RST}};
    end else begin
      if (upd_pulse) begin
        next_act = pend;
      end
      if (wr_pulse) begin
        if (u_if.wr_addr == CFG_ADDR) begin
          next_cfg  = u_if.wr_data;
          next_srst = u_if.wr_data[CFG_SRST_BIT];
        end else if (u_if.wr_addr == RBSEL_ADDR) begin
          next_rb_sel = u_if.wr_data[RB_PENDING_BIT];
        end
        for (int i = 0; i < BUF_N; i++) begin
          if (u_if.wr_addr == BUF_BASE + ADDR_W'(i)) begin
            next_pend[i] = u_if.wr_data;
          end
        end
      end
    end
  end

  // register state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_seen  <= 1'b0;
      upd_seen <= 1'b0;
      cfg      <= CFG_RST;
      rb_sel   <= RBSEL_RST;
      srst     <= 1'b0;
      pend     <= {BUF_N{BUF_RST}};
      act      <= {BUF_N{BUF_RST}};
    end else begin
      wr_seen  <= next_wr_seen;
      upd_seen <= next_upd_seen;
      cfg      <= next_cfg;
      rb_sel   <= next_rb_sel;
      srst     <= next_srst;
      pend     <= next_pend;
      act      <= next_act;
    end
  end

  // active settings out, one byte per buffered register
  generate
    for (genvar g = 0; g < BUF_N; g++) begin : g_act
      assign active_regs[g*8 +: 8] = act[g];
    end
  endgenerate

  // checks on the core clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_pin_bidir: assert property (
    (!cfg[CFG_PIN_SEL_BIT] || i2c_s) |-> !u_if.pin_sel)
    else $error("output pin select active while configured off");

  chk_pin_split: assert property (
    (cfg[CFG_PIN_SEL_BIT] && !i2c_s) |-> u_if.pin_sel)
    else $error("output pin select not active while configured on");

  chk_i2c_ignore: assert property (
    i2c_s |-> (!u_if.pin_sel && !u_if.lsb_first))
    else $error("mode bits acted upon in I2C mode");

  chk_msb_order: assert property (
    !cfg[CFG_LSB_BIT] |-> !u_if.lsb_first)
    else $error("LSB first active with bit order select at 0");

  chk_lsb_order: assert property (
    (cfg[CFG_LSB_BIT] && !i2c_s) |-> u_if.lsb_first)
    else $error("LSB first inactive with bit order select at 1");

  chk_srst_clears: assert property (
    (wr_pulse && !srst && u_if.wr_addr == CFG_ADDR && u_if.wr_data[CFG_SRST_BIT])
    |=> srst ##1 (!srst && cfg == CFG_RST && rb_sel == RBSEL_RST
                  && act == {BUF_N{BUF_RST}} && pend == {BUF_N{BUF_RST}}))
    else $error("soft reset did not restore defaults and self clear");

  chk_rsvd_bit4: assert property (
    (wr_pulse && !srst && u_if.wr_addr == CFG_ADDR && !u_if.wr_data[CFG_SRST_BIT]
     && u_if.wr_data[7:6] == cfg[7:6])
    |=> ($stable(u_if.pin_sel) && $stable(u_if.lsb_first)))
    else $error("reserved configuration bit changed port behaviour");

  chk_rb_active: assert property (
    (buf_rd_hit && !rb_sel) |-> u_if.rd_data == act[buf_rd_idx])
    else $error("buffered readback did not return active value");

  chk_rb_pending: assert property (
    (buf_rd_hit && rb_sel) |-> u_if.rd_data == pend[buf_rd_idx])
    else $error("buffered readback did not return pending value");

  chk_upd_copy: assert property (
    (upd_pulse && !srst) |=> act == $past(pend))
    else $error("I/O update did not copy pending set into active set");

  chk_act_hold: assert property (
    (!upd_pulse && !srst) |=> $stable(act))
    else $error("active set changed without an I/O update");

  // soft reset pulse: one cycle, only from a write, always to defaults
  chk_srst_self: assert property (
    srst |=> !srst)
    else $error("soft reset pulse lasted more than one cycle");

  chk_srst_source: assert property (
    srst |-> $past(wr_pulse))
    else $error("soft reset pulse without a configuration write");

  chk_srst_defaults: assert property (
    srst |=> (cfg == CFG_RST && rb_sel == RBSEL_RST
              && act == {BUF_N{BUF_RST}} && pend == {BUF_N{BUF_RST}}))
    else $error("register left off its default after soft reset");

  // register stores follow serial writes and nothing else
  chk_cfg_store: assert property (
    (wr_pulse && !srst && u_if.wr_addr == CFG_ADDR)
    |=> cfg == $past(u_if.wr_data))
    else $error("configuration byte not stored as written");

  chk_cfg_hold: assert property (
    (!wr_pulse && !srst) |=> $stable(cfg))
    else $error("configuration byte changed without a write");

  chk_rbsel_store: assert property (
    (wr_pulse && !srst && u_if.wr_addr == RBSEL_ADDR)
    |=> rb_sel == $past(u_if.wr_data[RB_PENDING_BIT]))
    else $error("readback select not stored as written");

  chk_rbsel_hold: assert property (
    (!wr_pulse && !srst) |=> $stable(rb_sel))
    else $error("readback select changed without a write");

  chk_pend_hold: assert property (
    (!wr_pulse && !srst) |=> $stable(pend))
    else $error("pending set changed without a write");

  // readback and pin drive
  chk_rd_cfg: assert property (
    (u_if.rd_addr == CFG_ADDR) |-> u_if.rd_data == cfg)
    else $error("configuration byte did not read back as stored");

  chk_rd_rbsel: assert property (
    (u_if.rd_addr == RBSEL_ADDR) |-> u_if.rd_data == {7'h00, rb_sel})
    else $error("readback select did not read back as stored");

  chk_pin_exclusive: assert property (
    !(sdio_oe && serial_out_oe))
    else $error("both data output pins driven at once");

  chk_oe_idle: assert property (
    cs_n |-> (!sdio_oe && !serial_out_oe))
    else $error("data output pin driven outside a frame");

  // each buffered entry: its own write lands in pending, its read follows the select
  generate
    for (genvar g = 0; g < BUF_N; g++) begin : g_chk_buf
      chk_pend_load: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_pulse && !srst && u_if.wr_addr == BUF_BASE + ADDR_W'(g))
        |=> pend[g] == $past(u_if.wr_data))
        else $error("buffered write did not land in the pending set");
      chk_rd_entry: assert property (
        @(posedge clk) disable iff (!rstn)
        (u_if.rd_addr == BUF_BASE + ADDR_W'(g))
        |-> u_if.rd_data == (rb_sel ? pend[g] : act[g]))
        else $error("buffered entry read back from the wrong set");
    end
  endgenerate

  // main scenarios
  cov_soft_reset: cover property (srst ##1 cfg == CFG_RST);
  cov_io_update:  cover property (upd_pulse ##1 act != {BUF_N{BUF_RST}});
  cov_rb_pending: cover property (buf_rd_hit && rb_sel && pend != act);
  cov_split_pins: cover property (u_if.pin_sel && u_if.lsb_first);
  cov_i2c_mode:   cover property (i2c_s && cfg[CFG_PIN_SEL_BIT] && !u_if.pin_sel);

endmodule

`default_nettype wire

//--- tb_spcr_top.sv
/*
  tb_spcr_top: self-checking bench for the serial port configuration registers.
  Assumes spcr_host_model stands on the serial link and the package constants hold.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_spcr_top import spcr_pkg::*; ;
  logic                    clk;
  logic                    rstn;
  logic                    i2c_mode;
  logic                    io_update;
  logic [31:0]             rd;
  int                      errors;
  int                      check_count;
  wire logic               sclk, cs_n, sdio_in, sdio_out, sdio_oe;
  wire logic               serial_out_pin, serial_out_oe;
  wire logic [BUF_N*8-1:0] active_regs;

  spcr_top spcr_top_inst (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .i2c_mode(i2c_mode), .io_update(io_update), .active_regs(active_regs));

  spcr_host_model spcr_host_model_inst (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe));

  // core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // comparison and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // frame helpers over the serial link
  task automatic wr(input logic [12:0] a, input logic l, input int n, input logic [31:0] d);
    spcr_host_model_inst.xfer(1'b0, a, l, n, d, rd);
  endtask

  task automatic rdchk(input logic [12:0] a, input logic l, input int n, input logic [31:0] e);
    spcr_host_model_inst.xfer(1'b1, a, l, n, 32'h0000_0000, rd);
    check(rd, e);
  endtask

  task automatic oechk(input logic two_way, input logic sep);
    check({31'h0, spcr_host_model_inst.saw_sdio_oe}, {31'h0, two_way});
    check({31'h0, spcr_host_model_inst.saw_so_oe}, {31'h0, sep});
  endtask

  // io update pulse, long enough for the two-flop chain
  task automatic upd;
    @(posedge clk) #1 io_update = 1'b1;
    repeat (4) @(posedge clk);
    #1 io_update = 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // hang guard
  initial begin
    #100000;
    errors++;
    summarize();
  end

  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    rstn = 1'b1;
    i2c_mode = 1'b0;
    io_update = 1'b0;
    // a definite falling edge clears the link's posted write state
    #1 rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    rdchk(CFG_ADDR, 1'b0, 1, 32'h0000_0000);
    oechk(1'b1, 1'b0);
    rdchk(RBSEL_ADDR, 1'b0, 1, 32'h0000_0000);
    wr(CFG_ADDR, 1'b0, 1, 32'h0000_0018);
    rdchk(CFG_ADDR, 1'b0, 1, 32'h0000_0018);
    wr(13'h0008, 1'b0, 1, 32'h0000_005a);
    rdchk(13'h0008, 1'b0, 1, 32'h0000_0000);
    // streaming write counts down from the top buffered byte
    wr(BUF_BASE + 13'h0003, 1'b0, 4, 32'h1122_3344);
    check(active_regs, 32'h0000_0000);
    rdchk(BUF_BASE + 13'h0003, 1'b0, 4, 32'h0000_0000);
    wr(RBSEL_ADDR, 1'b0, 1, 32'h0000_0001);
    rdchk(BUF_BASE + 13'h0003, 1'b0, 4, 32'h1122_3344);
    upd();
    check(active_regs, 32'h4433_2211);
    // lsb first, address counting up
    wr(CFG_ADDR, 1'b0, 1, 32'h0000_0042);
    wr(BUF_BASE, 1'b1, 4, 32'ha1b2_c3d4);
    rdchk(BUF_BASE, 1'b1, 4, 32'ha1b2_c3d4);
    check(active_regs, 32'h4433_2211);
    upd();
    check(active_regs, 32'ha1b2_c3d4);
    wr(RBSEL_ADDR, 1'b1, 1, 32'h0000_0000);
    rdchk(BUF_BASE + 13'h0001, 1'b1, 2, 32'h0000_b2c3);
    // separate output pin
    wr(CFG_ADDR, 1'b1, 1, 32'h0000_00c3);
    rdchk(CFG_ADDR, 1'b1, 1, 32'h0000_00c3);
    oechk(1'b0, 1'b1);
    // i2c mode ignores pin select and bit order
    @(posedge clk) #1 i2c_mode = 1'b1;
    repeat (4) @(posedge clk);
    rdchk(CFG_ADDR, 1'b0, 1, 32'h0000_00c3);
    oechk(1'b1, 1'b0);
    rdchk(BUF_BASE + 13'h0002, 1'b0, 2, 32'h0000_c3b2);
    wr(RBSEL_ADDR, 1'b0, 1, 32'h0000_0001);
    wr(BUF_BASE, 1'b0, 1, 32'h0000_0077);
    // soft reset restores every default and clears itself
    wr(CFG_ADDR, 1'b0, 1, 32'h0000_0024);
    rdchk(CFG_ADDR, 1'b0, 1, 32'h0000_0000);
    rdchk(RBSEL_ADDR, 1'b0, 1, 32'h0000_0000);
    rdchk(BUF_BASE, 1'b0, 1, 32'h0000_0000);
    check(active_regs, 32'h0000_0000);
    wr(RBSEL_ADDR, 1'b0, 1, 32'h0000_0001);
    rdchk(BUF_BASE, 1'b0, 1, 32'h0000_0000);
    @(posedge clk) #1 i2c_mode = 1'b0;
    repeat (4) @(posedge clk);
    rdchk(CFG_ADDR, 1'b0, 1, 32'h0000_0000);
    oechk(1'b1, 1'b0);
    summarize();
  end
endmodule

`default_nettype wire
